// File: core/serial_command_gateway.sv
// Gateway logic between controller process data and an RS 232 end device.
// Assumes an APB master on mclk and a raw serial line and switch on pins.
//
// Function
// - Command mode only while control bit 0.0 set
// - Rising command bit sends its mapped string
// - Replies forwarded unchanged, never interpreted
// - Position zero: zero byte ends telegram, dropped
// - Position zero: idle gap over 20 ms separates
// - Default link 9600 baud 8N1, no handshake
// - Switch picks framing; position zero transparent
// - Switch defaults zero; position F restores factory
// - Positions one, two: STX, data, CR, LF
// - Position one bits 0 to 7 mapping
// - Position one bits 8 to 14 mapping
// - Position two bits 0 to 8 mapping
// - Position two bits 11 to 14 mapping
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`include "serial_command_gateway_map.svh"
module serial_command_gateway #(
   parameter int IDLE_GAP_CYCLES = `GW_IDLE_GAP_CYCLES
) (
   input  wire logic        mclk,                  // 20 MHz clock
   input  wire logic        rst,                   // Synchronous reset
   input  wire logic        psel,                  // APB select
   input  wire logic        penable,               // APB enable
   input  wire logic        pwrite,                // APB direction
   input  wire logic [7:0]  paddr,                 // APB byte address
   input  wire logic [31:0] pwdata,                // APB write data
   output logic      [31:0] prdata,                // APB read data
   output logic             pready,                // APB ready
   output logic             pslverr,               // APB error
   input  wire logic [3:0]  deviceSelectionSwitch, // Rotary switch pins
   input  wire logic        serRx,                 // Serial from end device
   output logic             serTx                  // Serial to end device
);
   localparam int GW = $clog2(IDLE_GAP_CYCLES + 1);

   // Switch synchroniser
   logic [3:0] swMeta1_reg, swMeta2_reg, swMeta3_reg, swPos_reg;
   always_ff @(posedge mclk) begin
      swMeta1_reg <= deviceSelectionSwitch;
      swMeta2_reg <= swMeta1_reg;
      swMeta3_reg <= swMeta2_reg;
      if (rst) swPos_reg <= `GW_POS_TRANSPARENT;
      else if (swMeta2_reg == swMeta3_reg) swPos_reg <= swMeta3_reg;
   end
   wire factoryPos = (swPos_reg == `GW_POS_FACTORY);
   wire framedPos  = (swPos_reg == `GW_POS_PROFILE_A) || (swPos_reg == `GW_POS_PROFILE_B);
   wire transpPos  = (swPos_reg == `GW_POS_TRANSPARENT);

   // APB decode
   wire access    = psel && penable;
   wire selCtrl   = (paddr == `GW_OFF_CTRL);
   wire selCfg    = (paddr == `GW_OFF_CFG);
   wire selTx     = (paddr == `GW_OFF_TXDATA);
   wire selRx     = (paddr == `GW_OFF_RXDATA);
   wire selStat   = (paddr == `GW_OFF_STATUS);
   wire mapped    = selCtrl || selCfg || selTx || selRx || selStat;
   logic txHoldValid_reg;
   wire txStall   = access && pwrite && selTx && txHoldValid_reg;
   wire done      = access && !txStall;
   wire wrCtrl    = done && pwrite && selCtrl;
   wire wrCfg     = done && pwrite && selCfg;
   wire wrTx      = done && pwrite && selTx;
   wire wrStat    = done && pwrite && selStat;
   wire rdRx      = done && !pwrite && selRx;
   assign pready  = !txStall;
   assign pslverr = access && !mapped;

   // Control and configuration registers
   logic [31:0] ctrl_reg, cfg_reg;
   always_ff @(posedge mclk) begin
      if (rst || factoryPos) begin
         ctrl_reg <= `GW_CTRL_RESET;
         cfg_reg  <= `GW_CFG_RESET;
      end else begin
         if (wrCtrl) ctrl_reg <= pwdata;
         if (wrCfg) cfg_reg <= pwdata;
      end
   end
   wire        cmdMode  = ctrl_reg[`GW_CTRL_MODE_BIT];
   wire [15:0] cmdBits  = ctrl_reg[`GW_CTRL_CMD_LSB +: 16];
   wire [15:0] baudDiv  = cfg_reg[`GW_CFG_DIV_MSB:0];
   wire        twoStop  = cfg_reg[`GW_CFG_TWOSTOP_BIT];

   // Edge detection of command bits
   logic [15:0] cmdPrev_reg, pendRise_reg, pendFall_reg;
   logic [15:0] clrRise, clrFall;
   wire  [15:0] rise = cmdMode ? (cmdBits & ~cmdPrev_reg) : 16'h0000;
   wire  [15:0] fall = cmdMode ? (~cmdBits & cmdPrev_reg & 16'h0012) : 16'h0000;
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmdPrev_reg  <= 16'h0000;
         pendRise_reg <= 16'h0000;
         pendFall_reg <= 16'h0000;
      end else begin
         cmdPrev_reg <= cmdBits;
         if (!cmdMode) begin
            pendRise_reg <= 16'h0000;
            pendFall_reg <= 16'h0000;
         end else begin
            pendRise_reg <= (pendRise_reg & ~clrRise) | rise;
            pendFall_reg <= (pendFall_reg & ~clrFall) | fall;
         end
      end
   end

   // Command text for a bit in the active profile
   function automatic serial_command_gateway_pkg::cmd_str_type cmd_lookup(
      input logic [3:0] pos,
      input logic [3:0] idx,
      input logic       minus
   );
      serial_command_gateway_pkg::cmd_str_type s;
      logic twoOutputs;
      s          = '0;
      twoOutputs = (pos == `GW_POS_PROFILE_B);
      if (pos == `GW_POS_PROFILE_A || pos == `GW_POS_PROFILE_B) begin
         case (idx)
            4'h0: s = '{3'd1, {8'h00, 8'h00, 8'h00, 8'h76}};
            4'h1: s = '{3'd1, {8'h00, 8'h00, 8'h00, minus ? 8'h2d : 8'h2b}};
            4'h2: s = '{3'd3, {8'h00, 8'h31, 8'h54, 8'h52}};
            4'h3: s = '{3'd3, {8'h00, 8'h32, 8'h54, 8'h52}};
            4'h4: s = '{3'd3, {8'h00, minus ? 8'h2d : 8'h2b, 8'h41, 8'h43}};
            4'h5: s = '{3'd3, {8'h00, 8'h31, 8'h41, 8'h4f}};
            4'h6: if (twoOutputs) s = '{3'd3, {8'h00, 8'h32, 8'h41, 8'h4f}};
            4'h7: s = '{3'd3, {8'h00, 8'h31, 8'h44, 8'h4f}};
            4'h8: s = twoOutputs ? '{3'd3, {8'h00, 8'h32, 8'h44, 8'h4f}}
                                 : '{3'd3, {8'h00, 8'h53, 8'h4f, 8'h53}};
            4'h9: if (!twoOutputs) s = '{3'd3, {8'h00, 8'h4e, 8'h4f, 8'h53}};
            4'ha: if (!twoOutputs) s = '{3'd3, {8'h00, 8'h3f, 8'h52, 8'h41}};
            4'hb: s = '{3'd2, {8'h00, 8'h00, 8'h42, 8'h56}};
            4'hc: s = '{3'd2, {8'h00, 8'h00, 8'h4b, 8'h56}};
            4'hd: s = '{3'd4, {8'h30, 8'h32, 8'h43, 8'h50}};
            4'he: s = '{3'd1, {8'h00, 8'h00, 8'h00, 8'h48}};
            default: s = '0;
         endcase
      end
      cmd_lookup = s;
   endfunction

   // Index of the lowest set bit
   function automatic logic [3:0] lowest(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) r = 4'(i);
      end
      lowest = r;
   endfunction

   // Telegram builder
   wire        useFall  = (pendRise_reg == 16'h0000);
   wire [15:0] pendSel  = useFall ? pendFall_reg : pendRise_reg;
   wire [3:0]  pickIdx  = lowest(pendSel);
   wire        pickAny  = (pendSel != 16'h0000);
   serial_command_gateway_pkg::cmd_str_type  pickStr;
   serial_command_gateway_pkg::telegram_type pickTel;
   assign pickStr = cmd_lookup(swPos_reg, pickIdx, useFall);
   always_comb begin
      pickTel = '0;
      if (framedPos) begin
         pickTel.bytes[0] = `GW_CHAR_STX;
         for (int i = 0; i < 4; i++) begin
            pickTel.bytes[i+1] = pickStr.chars[i];
         end
         pickTel.bytes[pickStr.len + 3'd1] = `GW_CHAR_CR;
         pickTel.bytes[pickStr.len + 3'd2] = `GW_CHAR_LF;
         pickTel.len = pickStr.len + 3'd3;
      end
   end

   // Transparent data byte from software
   logic [7:0] txHold_reg;
   logic       zeroSeen_reg;
   wire        zeroDrop = wrTx && transpPos && (pwdata[7:0] == 8'h00);

   // Sequencer feeding the transmit buffer
   serial_command_gateway_pkg::seq_state_type seqState_reg;
   serial_command_gateway_pkg::telegram_type  tel_reg;
   logic [2:0] seqIdx_reg;
   logic [7:0] bufInData;
   logic       bufInValid, bufInReady;
   wire        seqIdle  = (seqState_reg == serial_command_gateway_pkg::SEQ_IDLE);
   wire        startTel = seqIdle && pickAny && pickStr.len != 3'd0;
   wire        skipTel  = seqIdle && pickAny && pickStr.len == 3'd0;
   wire        holdSend = seqIdle && !pickAny && txHoldValid_reg;
   assign clrRise    = (startTel || skipTel) && !useFall ? (16'h0001 << pickIdx) : 16'h0000;
   assign clrFall    = (startTel || skipTel) && useFall ? (16'h0001 << pickIdx) : 16'h0000;
   assign bufInValid = !seqIdle || holdSend;
   assign bufInData  = seqIdle ? txHold_reg : tel_reg.bytes[seqIdx_reg];

   always_ff @(posedge mclk) begin
      if (rst) begin
         seqState_reg <= serial_command_gateway_pkg::SEQ_IDLE;
         tel_reg      <= '0;
         seqIdx_reg   <= 3'd0;
      end else if (startTel) begin
         seqState_reg <= serial_command_gateway_pkg::SEQ_SEND;
         tel_reg      <= pickTel;
         seqIdx_reg   <= 3'd0;
      end else if (!seqIdle && bufInReady) begin
         seqIdx_reg <= seqIdx_reg + 3'd1;
         if (seqIdx_reg + 3'd1 == tel_reg.len) seqState_reg <= serial_command_gateway_pkg::SEQ_IDLE;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         txHoldValid_reg <= 1'b0;
         txHold_reg      <= 8'h00;
      end else if (wrTx && !zeroDrop) begin
         txHoldValid_reg <= 1'b1;
         txHold_reg      <= pwdata[7:0];
      end else if (holdSend && bufInReady) begin
         txHoldValid_reg <= 1'b0;
      end
   end

   logic [7:0] txByte;
   logic       txByteValid, txTake;
   two_entry_buffer #(.WIDTH(8), .DEPTH(2)) txBuffer (
      .mclk     (mclk),
      .rst      (rst),
      .inData   (bufInData),
      .inValid  (bufInValid),
      .inReady  (bufInReady),
      .outData  (txByte),
      .outValid (txByteValid),
      .outReady (txTake)
   );

   // Serial transmitter, no handshake lines
   logic [10:0] txShift_reg;
   logic [3:0]  txBits_reg;
   logic [15:0] txCnt_reg;
   wire         txBusy  = (txBits_reg != 4'd0);
   wire         txTick  = (txCnt_reg == 16'h0000);
   assign txTake = !txBusy;
   always_ff @(posedge mclk) begin
      if (rst) begin
         txShift_reg <= 11'h7ff;
         txBits_reg  <= 4'd0;
         txCnt_reg   <= 16'h0000;
         serTx       <= 1'b1;
      end else if (!txBusy) begin
         serTx <= 1'b1;
         if (txByteValid) begin
            txShift_reg <= {2'b11, txByte, 1'b0};
            txBits_reg  <= twoStop ? 4'd12 : 4'd11;
            txCnt_reg   <= 16'h0000;
         end
      end else if (txTick) begin
         serTx       <= txShift_reg[0];
         txShift_reg <= {1'b1, txShift_reg[10:1]};
         txBits_reg  <= txBits_reg - 4'd1;
         txCnt_reg   <= baudDiv - 16'h0001;
      end else begin
         txCnt_reg <= txCnt_reg - 16'h0001;
      end
   end

   // Receive line synchroniser
   logic rxMeta1_reg, rxMeta2_reg, rxMeta3_reg, rxLevel_reg;
   always_ff @(posedge mclk) begin
      rxMeta1_reg <= serRx;
      rxMeta2_reg <= rxMeta1_reg;
      rxMeta3_reg <= rxMeta2_reg;
      if (rst) rxLevel_reg <= 1'b1;
      else if (rxMeta2_reg == rxMeta3_reg) rxLevel_reg <= rxMeta3_reg;
   end

   // Serial receiver
   logic        rxActive_reg, rxDone_reg;
   logic [3:0]  rxBit_reg;
   logic [15:0] rxCnt_reg;
   logic [7:0]  rxShift_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxActive_reg <= 1'b0;
         rxDone_reg   <= 1'b0;
         rxBit_reg    <= 4'd0;
         rxCnt_reg    <= 16'h0000;
         rxShift_reg  <= 8'h00;
      end else begin
         rxDone_reg <= 1'b0;
         if (!rxActive_reg) begin
            if (!rxLevel_reg) begin
               rxActive_reg <= 1'b1;
               rxBit_reg    <= 4'd0;
               rxCnt_reg    <= {1'b0, baudDiv[15:1]};
            end
         end else if (rxCnt_reg != 16'h0000) begin
            rxCnt_reg <= rxCnt_reg - 16'h0001;
         end else begin
            rxCnt_reg <= baudDiv - 16'h0001;
            rxBit_reg <= rxBit_reg + 4'd1;
            if (rxBit_reg == 4'd0 && rxLevel_reg) rxActive_reg <= 1'b0;
            else if (rxBit_reg >= 4'd1 && rxBit_reg <= 4'd8) begin
               rxShift_reg <= {rxLevel_reg, rxShift_reg[7:1]};
            end else if (rxBit_reg == 4'd9) begin
               rxActive_reg <= 1'b0;
               rxDone_reg   <= rxLevel_reg;
            end
         end
      end
   end

   logic [7:0] rxByte;
   logic       rxByteValid, rxInReady;
   two_entry_buffer #(.WIDTH(8), .DEPTH(2)) rxBuffer (
      .mclk     (mclk),
      .rst      (rst),
      .inData   (rxShift_reg),
      .inValid  (rxDone_reg),
      .inReady  (rxInReady),
      .outData  (rxByte),
      .outValid (rxByteValid),
      .outReady (rdRx)
   );

   // Idle gap marks end of a received telegram
   logic [GW-1:0] gapCnt_reg;
   logic          gapArmed_reg, gapSeen_reg, overrun_reg;
   wire           gapHit = gapArmed_reg && (gapCnt_reg == GW'(IDLE_GAP_CYCLES)) && transpPos;
   always_ff @(posedge mclk) begin
      if (rst) begin
         gapCnt_reg   <= '0;
         gapArmed_reg <= 1'b0;
      end else if (rxActive_reg || rxDone_reg) begin
         gapCnt_reg   <= '0;
         gapArmed_reg <= 1'b1;
      end else if (gapCnt_reg != GW'(IDLE_GAP_CYCLES)) begin
         gapCnt_reg <= gapCnt_reg + GW'(1);
      end else if (gapHit) begin
         gapArmed_reg <= 1'b0;
      end
   end

   // Sticky status flags, set wins over write-one clear
   wire [31:0] w1c = wrStat ? pwdata : 32'h0;
   always_ff @(posedge mclk) begin
      if (rst) begin
         gapSeen_reg  <= 1'b0;
         overrun_reg  <= 1'b0;
         zeroSeen_reg <= 1'b0;
      end else begin
         gapSeen_reg  <= gapHit || (gapSeen_reg && !w1c[`GW_ST_GAP_BIT]);
         overrun_reg  <= (rxDone_reg && !rxInReady) || (overrun_reg && !w1c[`GW_ST_OVR_BIT]);
         zeroSeen_reg <= zeroDrop || (zeroSeen_reg && !w1c[`GW_ST_ZERO_BIT]);
      end
   end

   // Read data mux
   logic [31:0] status;
   always_comb begin
      status                  = 32'h0;
      status[3:0]             = swPos_reg;
      status[`GW_ST_BUSY_BIT] = !seqIdle || txBusy || txByteValid || txHoldValid_reg;
      status[`GW_ST_GAP_BIT]  = gapSeen_reg;
      status[`GW_ST_OVR_BIT]  = overrun_reg;
      status[`GW_ST_ZERO_BIT] = zeroSeen_reg;
      status[`GW_ST_MODE_BIT] = cmdMode;
   end

   wire [31:0] rxWord = {23'h0, rxByteValid, rxByteValid ? rxByte : 8'h00};
   wire [31:0] rdMux  = selCtrl ? ctrl_reg :
                        selCfg  ? cfg_reg  :
                        selRx   ? rxWord   :
                        selStat ? status   : 32'h0;
   always_ff @(posedge mclk) begin
      if (rst) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= rdMux;
   end
endmodule

// File: core/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module two_entry_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             mclk,     // System clock
   input  wire logic             rst,      // Synchronous reset
   input  wire logic [WIDTH-1:0] inData,   // Word offered
   input  wire logic             inValid,  // Word offered valid
   output logic                  inReady,  // Space available
   output logic      [WIDTH-1:0] outData,  // Oldest word
   output logic                  outValid, // Buffer not empty
   input  wire logic             outReady  // Drain accepts word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wrPtr_reg;
   logic [PW-1:0]    rdPtr_reg;
   logic [PW:0]      count_reg;

   wire push = inValid && inReady;
   wire pop  = outValid && outReady;

   function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
      advance = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign inReady  = (count_reg != (PW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData  = store[rdPtr_reg];

   always_ff @(posedge mclk) begin
      if (push) begin
         store[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wrPtr_reg <= advance(wrPtr_reg);
         if (pop) rdPtr_reg <= advance(rdPtr_reg);
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// File: include/serial_command_gateway_map.svh
// Register offsets, field positions, reset values and timing counts
// for the serial command gateway. Definitions only.
`ifndef SERIAL_COMMAND_GATEWAY_MAP_SVH
`define SERIAL_COMMAND_GATEWAY_MAP_SVH

// Clock and serial timing
`define GW_CLK_HZ            20000000
`define GW_BAUD_DEFAULT      9600
`define GW_BAUD_DIV_RESET    (`GW_CLK_HZ / `GW_BAUD_DEFAULT)
`define GW_IDLE_GAP_MS       20
`define GW_IDLE_GAP_CYCLES   ((`GW_CLK_HZ / 1000) * `GW_IDLE_GAP_MS)

// Register byte offsets
`define GW_OFF_CTRL          8'h00
`define GW_OFF_CFG           8'h04
`define GW_OFF_TXDATA        8'h08
`define GW_OFF_RXDATA        8'h0c
`define GW_OFF_STATUS        8'h10

// Control register fields
`define GW_CTRL_MODE_BIT     0
`define GW_CTRL_CMD_LSB      16
`define GW_CTRL_RESET        32'h0000_0000

// Configuration register fields
`define GW_CFG_DIV_MSB       15
`define GW_CFG_TWOSTOP_BIT   16
`define GW_CFG_TRANSP_BIT    17
`define GW_CFG_RESET         (32'h0002_0000 | `GW_BAUD_DIV_RESET)

// Receive data and status fields
`define GW_RX_VALID_BIT      8
`define GW_ST_BUSY_BIT       4
`define GW_ST_GAP_BIT        5
`define GW_ST_OVR_BIT        6
`define GW_ST_ZERO_BIT       7
`define GW_ST_MODE_BIT       8

// Switch positions and framing characters
`define GW_POS_TRANSPARENT   4'h0
`define GW_POS_PROFILE_A     4'h1
`define GW_POS_PROFILE_B     4'h2
`define GW_POS_FACTORY       4'hf
`define GW_CHAR_STX          8'h02
`define GW_CHAR_CR           8'h0d
`define GW_CHAR_LF           8'h0a

`endif

// File: include/serial_command_gateway_pkg.sv
// Types shared by the serial command gateway files.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_command_gateway_pkg;

   // Command text of up to four ASCII characters
   typedef struct packed {
      logic [2:0]      len;
      logic [3:0][7:0] chars;
   } cmd_str_type;

   // Complete telegram of up to seven bytes
   typedef struct packed {
      logic [2:0]      len;
      logic [6:0][7:0] bytes;
   } telegram_type;

   typedef enum logic [0:0] {
      SEQ_IDLE,
      SEQ_SEND
   } seq_state_type;

endpackage

// File: test/end_device_model.sv
// End device model: 8N1 serial receiver and sender, no handshake.
// Assumes the bench gives the bit time in clocks on bitCycles.
`timescale 1ns/10ps
module end_device_model (
   input  wire logic        mclk,      // Clock
   input  wire logic [15:0] bitCycles, // Clocks per bit
   input  wire logic        serTx,     // From gateway
   output logic             serRx      // To gateway, idle high
);
   logic [7:0] rxq[$];
   logic [7:0] b;
   initial serRx = 1'b1;
   // Mid-bit sampling; byte kept only with a valid stop bit
   initial begin
      forever begin
         @(negedge serTx);
         repeat (bitCycles / 2) @(posedge mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (bitCycles) @(posedge mclk);
            b[i] = serTx;
         end
         repeat (bitCycles) @(posedge mclk);
         if (serTx) rxq.push_back(b);
      end
   end
   task automatic send_byte(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         serRx <= f[i];
         repeat (bitCycles) @(posedge mclk);
      end
   endtask
endmodule

// File: test/serial_command_gateway_sva.sv
// Checker on the gateway ports: APB answers and serial idle level.
// Assumes it is bound onto the gateway top module.
`timescale 1ns/10ps
module serial_command_gateway_sva (
   input wire logic        mclk,    // Clock
   input wire logic        rst,     // Reset
   input wire logic        psel,    // Select
   input wire logic        penable, // Enable
   input wire logic        pwrite,  // Direction
   input wire logic [7:0]  paddr,   // Address
   input wire logic [31:0] prdata,  // Read data
   input wire logic        pready,  // Ready
   input wire logic        pslverr, // Error
   input wire logic        serTx    // Serial out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire         acc    = psel && penable;
   wire         mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   logic [15:0] stallCnt;
   always_ff @(posedge mclk) stallCnt <= (rst || !acc || pready) ? 16'h0 : stallCnt + 16'h1;
   chk_tx_reset: assert property (disable iff (1'b0) rst |=> serTx)
      else $error("serial out not idle after reset");
   chk_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("unmapped access not refused");
   chk_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
   chk_err_idle: assert property (!acc |-> !pslverr) else $error("error outside access");
   chk_read_ready: assert property (acc && !pwrite |-> pready) else $error("read stalled");
   chk_write_ready: assert property (acc && pwrite && paddr != 8'h08 |-> pready)
      else $error("non data write stalled");
   chk_bad_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_stall_bound: assert property (stallCnt < 16'h7530) else $error("write stall too long");
   cov_stall: cover property (acc && !pready);
   cov_unmapped: cover property (acc && !mapped);
   cov_tx_start: cover property ($fell(serTx));
endmodule
bind serial_command_gateway serial_command_gateway_sva serial_command_gateway_sva_i (
   .mclk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .serTx);

// File: test/testbench.sv
// Self-checking bench: APB accesses, switch positions, end device model.
// Assumes gateway, buffer, checker and model are compiled first.
`timescale 1ns/10ps
module testbench;
   logic        mclk      = 1'b0;
   logic        rst       = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  sw        = 4'h0;
   logic [15:0] bitCycles = 16'h0823;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serRx;
   logic        serTx;
   int          nErrors   = 0;
   int          cmpCount  = 0;
   int          cycles    = 0;
   logic [31:0] q;
   logic        e;
   string       txt;
   string       p1[15] = '{"v", "+", "RT1", "RT2", "CA+", "OA1", "", "OD1", "SOS", "SON", "AR?", "VB", "VK", "PC20", "H"};
   string       p2[16] = '{"v", "+", "RT1", "RT2", "CA+", "OA1", "OA2", "OD1", "OD2", "", "", "VB", "VK", "PC20", "H", ""};
   serial_command_gateway #(.IDLE_GAP_CYCLES(200)) serial_command_gateway_i (
      .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .deviceSelectionSwitch(sw), .serRx, .serTx);
   end_device_model end_device_model_i (.mclk, .bitCycles, .serTx, .serRx);
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 80000) begin
         nErrors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 30000);
      if (pready !== 1'b1) check("apb ready", {31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] d;
      logic        r;
      apb(1'b0, a, 32'h0, d, r);
      check(nm, d & m, x);
   endtask
   // Waits for a whole telegram, then watches for stray bytes
   task automatic expect_tel(input string s, input logic framed);
      logic [7:0] x[$];
      int         n;
      n = 0;
      if (framed) x.push_back(8'h02);
      foreach (s[i]) x.push_back(s[i]);
      if (framed) x.push_back(8'h0d);
      if (framed) x.push_back(8'h0a);
      while (end_device_model_i.rxq.size() < x.size() && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      repeat (200) @(posedge mclk);
      check("telegram length", end_device_model_i.rxq.size(), x.size());
      foreach (x[i]) if (i < end_device_model_i.rxq.size()) check("telegram byte", end_device_model_i.rxq[i], x[i]);
      end_device_model_i.rxq = {};
   endtask
   task automatic send_cmd(input int b, input string s);
      apb(1'b1, 8'h00, 32'h1 | (32'h1 << (16 + b)), q, e);
      expect_tel(s, s.len() > 0);
      apb(1'b1, 8'h00, 32'h1, q, e);
      if (b == 1) expect_tel("-", 1'b1);
      else if (b == 4) expect_tel("CA-", 1'b1);
      else expect_tel("", 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      rdc("cfg reset", 8'h04, 32'hffff_ffff, 32'h0002_0823);
      rdc("ctrl reset", 8'h00, 32'hffff_ffff, 32'h0);
      rdc("switch default", 8'h10, 32'hf, 32'h0);
      apb(1'b0, 8'h14, 32'h0, q, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      check("unmapped data", q, 32'h0);
      apb(1'b1, 8'h04, 32'h0000_0008, q, e);
      bitCycles <= 16'h0008;
      $display("test map done");
      sw <= 4'h1;
      repeat (8) @(posedge mclk);
      apb(1'b1, 8'h00, 32'h0001_0000, q, e);
      expect_tel("", 1'b0);
      apb(1'b1, 8'h00, 32'h0, q, e);
      apb(1'b1, 8'h00, 32'h1, q, e);
      rdc("mode flag", 8'h10, 32'h100, 32'h100);
      foreach (p1[i]) send_cmd(i, p1[i]);
      end_device_model_i.send_byte(8'h41);
      end_device_model_i.send_byte(8'h00);
      repeat (20) @(posedge mclk);
      rdc("reply byte", 8'h0c, 32'h1ff, 32'h141);
      rdc("reply zero", 8'h0c, 32'h1ff, 32'h100);
      $display("test position one done");
      sw <= 4'h2;
      repeat (8) @(posedge mclk);
      foreach (p2[i]) send_cmd(i, p2[i]);
      $display("test position two done");
      sw <= 4'h0;
      repeat (8) @(posedge mclk);
      apb(1'b1, 8'h00, 32'h0, q, e);
      txt = "Zq<C!";
      foreach (txt[i]) apb(1'b1, 8'h08, {24'h0, txt[i]}, q, e);
      apb(1'b1, 8'h08, 32'h0, q, e);
      expect_tel(txt, 1'b0);
      rdc("zero dropped", 8'h10, 32'h90, 32'h80);
      apb(1'b1, 8'h10, 32'h0000_00e0, q, e);
      end_device_model_i.send_byte(8'h5a);
      rdc("gap early", 8'h10, 32'h20, 32'h0);
      repeat (300) @(posedge mclk);
      rdc("gap seen", 8'h10, 32'h20, 32'h20);
      rdc("raw reply", 8'h0c, 32'h1ff, 32'h15a);
      apb(1'b1, 8'h04, 32'h0001_0008, q, e);
      apb(1'b1, 8'h08, 32'h0000_0055, q, e);
      expect_tel("U", 1'b0);
      $display("test position zero done");
      sw <= 4'hf;
      repeat (8) @(posedge mclk);
      rdc("factory cfg", 8'h04, 32'hffff_ffff, 32'h0002_0823);
      $display("test factory done");
      final_report();
   end
endmodule
